// [rtl/uie_pkg.sv]
// uie_pkg: register offsets, field positions, reset values and source codes
// assumes: one channel of a quad uart, 8-bit register port, 3-bit address
package uie_pkg;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 3;
    localparam int          LVL_W         = 7;
    // register offsets on the parallel register port
    localparam logic [2:0]  OFS_MASK      = 3'h1;
    localparam logic [2:0]  OFS_FCTL_SRC  = 3'h2;
    localparam logic [2:0]  OFS_LSTAT     = 3'h5;
    localparam logic [7:0]  MASK_RST      = 8'h00;
    localparam logic [7:0]  FCTL_RST      = 8'h00;
    localparam logic [7:0]  LSTAT_RST     = 8'h60;
    // mask register fields
    localparam int          MB_RECEIVE_DMA_REQUEST_N      = 0;
    localparam int          MB_TXEMP      = 1;
    localparam int          MB_LINE       = 2;
    localparam int          MB_MODEM      = 3;
    localparam int          MB_SLEEP      = 4;
    localparam int          MB_XOFF       = 5;
    localparam int          MB_RTS        = 6;
    localparam int          MB_CTS        = 7;
    localparam logic [7:0]  MASK_ENH      = 8'hf0;
    // fifo control fields
    localparam int          FB_FIFO_EN    = 0;
    localparam int          FB_DMA_SEL    = 3;
    // line status fields
    localparam int          LB_DREADY     = 0;
    localparam int          LB_ERR_LO     = 1;
    localparam int          LB_THR_EMP    = 5;
    localparam int          LB_TX_IDLE    = 6;
    localparam int          LB_FIFO_ERR   = 7;
    // interrupt source codes, bits 5:0 of the source register
    localparam logic [5:0]  SRC_NONE      = 6'h01;
    localparam logic [5:0]  SRC_LINE      = 6'h06;
    localparam logic [5:0]  SRC_RECEIVE_DMA_REQUEST_N     = 6'h04;
    localparam logic [5:0]  SRC_TXEMP     = 6'h02;
    localparam logic [5:0]  SRC_MODEM     = 6'h00;
    localparam logic [5:0]  SRC_XOFF      = 6'h10;
    localparam logic [5:0]  SRC_HSHAKE    = 6'h20;
    localparam logic [1:0]  SRC_FIFO_ON   = 2'h3;
endpackage : uie_pkg

// [rtl/uie_rise_det.sv]
// uie_rise_det: one-cycle pulse on a low-to-high change of a level input
// assumes: the input is synchronous to clock
`timescale 1ns/100ps
module uie_rise_det (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic level,
    output logic      rise
);
    logic last_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_ff <= 1'b0;
        end else begin
            last_ff <= level;
        end
    end

    assign rise = level & ~last_ff;
endmodule : uie_rise_det

// [rtl/uie_sticky.sv]
// uie_sticky: pending flag set by an event and cleared by a strobe
// assumes: set and clear are one-cycle pulses synchronous to clock
`timescale 1ns/100ps
module uie_sticky (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag_ff
);
    // a set in the clearing cycle wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else if (set) begin
            flag_ff <= 1'b1;
        end else if (clr) begin
            flag_ff <= 1'b0;
        end
    end
endmodule : uie_sticky

// [rtl/uie_irq_ctrl.sv]
// uie_irq_ctrl: interrupt masking, source reporting, line status and dma ready
// assumes: fifos, shifters and modem logic sit outside and report levels/pulses
//
// Overview of operation
// - mask bit 7 enables cts rising interrupt
// - mask bit 6 enables rts rising interrupt
// - mask bit 5 enables xoff received interrupt
// - mask bit 4 enables sleep mode
// - mask bit 3 gates modem status interrupt
// - mask bit 2 gates line status interrupt
// - mask bit 1 interrupts while holding empty
// - mask bit 0: receive fill reaches trigger in fifo mode, data ready otherwise
// - mask register resets to all zero
// - source register shows trigger, clears together
// - data ready set on push, clear empty
// - host may poll with bits 0-3 clear
// - line status 1-4 report receive errors
// - line status 5 means transmit fifo empty
// - line status 6 means transmitter fully idle
// - line status 7 flags errored fifo character
// - dma mode 0 transmit request low when space
// - dma mode 0 receive request low when loaded
// - own output or shared wired request line
// - mask bits 4-7 need enhanced enable
`timescale 1ns/100ps
module uie_irq_ctrl #(
    parameter int LVL_W = uie_pkg::LVL_W
) (
    input  wire logic             clock,
    input  wire logic             rst,
    // parallel register port
    input  wire logic [2:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    input  wire logic             divisor_latch_sel,
    input  wire logic             enh_enable,
    // status from the rest of the channel
    input  wire logic             cts_level,
    input  wire logic             rts_level,
    input  wire logic             xoff_rcvd,
    input  wire logic             modem_change,
    input  wire logic             modem_status_rd,
    input  wire logic [3:0]       rx_err,
    input  wire logic             rx_push,
    input  wire logic [LVL_W-1:0] rx_fill,
    input  wire logic [LVL_W-1:0] rx_trigger,
    input  wire logic             rx_fifo_err,
    input  wire logic             thr_empty,
    input  wire logic             tsr_empty,
    input  wire logic             bus_mode_68,
    // outputs
    output logic                  sleep_enable,
    output logic                  channel_irq,
    output logic                  shared_irq_out,
    output logic                  shared_irq_oe,
    output logic                  transmit_dma_request_n,
    output logic                  receive_dma_request_n
);
    if (LVL_W < 2 || LVL_W > 16) begin : g_bad_lvl_w
        $error("uie_irq_ctrl: LVL_W out of range");
    end

    logic [7:0] interrupt_mask_ff;
    logic [7:0] fifo_ctl_ff;
    logic [3:0] err_ff;
    logic       dready_ff;
    logic       irq_ff;
    logic       transmit_dma_request_n_n_ff;
    logic       receive_dma_request_n_n_ff;
    logic [7:0] rdata_ff;
    logic       cts_rise;
    logic       rts_rise;
    logic       cts_pend_ff;
    logic       rts_pend_ff;
    logic       xoff_pend_ff;
    logic       modem_pend_ff;
    logic       line_pend_ff;
    logic       wr_mask;
    logic       wr_fctl;
    logic       rd_src;
    logic       rd_lstat;
    logic       fifo_on;
    logic       rx_level;
    logic       any_err;
    logic [7:0] mask_rd;
    logic [7:0] lstat;
    logic [5:0] src_code;
    logic       nxt_irq;

    assign wr_mask  = reg_wr && !divisor_latch_sel && reg_addr == uie_pkg::OFS_MASK;
    assign wr_fctl  = reg_wr && !divisor_latch_sel && reg_addr == uie_pkg::OFS_FCTL_SRC;
    assign rd_src   = reg_rd && !divisor_latch_sel && reg_addr == uie_pkg::OFS_FCTL_SRC;
    assign rd_lstat = reg_rd && reg_addr == uie_pkg::OFS_LSTAT;
    assign fifo_on  = fifo_ctl_ff[uie_pkg::FB_FIFO_EN];
    assign any_err  = |rx_err;

    // mask register; upper half only reachable with enhanced enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_mask_ff <= uie_pkg::MASK_RST;
        end else if (wr_mask) begin
            if (enh_enable) begin
                interrupt_mask_ff <= reg_wdata;
            end else begin
                interrupt_mask_ff <= (interrupt_mask_ff & uie_pkg::MASK_ENH)
                                   | (reg_wdata & ~uie_pkg::MASK_ENH);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fifo_ctl_ff <= uie_pkg::FCTL_RST;
        end else if (wr_fctl) begin
            fifo_ctl_ff <= reg_wdata;
        end
    end

    assign sleep_enable = interrupt_mask_ff[uie_pkg::MB_SLEEP];

    uie_rise_det u_cts_rise (
        .clock (clock),
        .rst   (rst),
        .level (cts_level),
        .rise  (cts_rise)
    );

    uie_rise_det u_rts_rise (
        .clock (clock),
        .rst   (rst),
        .level (rts_level),
        .rise  (rts_rise)
    );

    // handshake and xoff pendings clear on a source register read
    uie_sticky u_cts_pend (
        .clock   (clock),
        .rst     (rst),
        .set     (cts_rise),
        .clr     (rd_src),
        .flag_ff (cts_pend_ff)
    );

    uie_sticky u_rts_pend (
        .clock   (clock),
        .rst     (rst),
        .set     (rts_rise),
        .clr     (rd_src),
        .flag_ff (rts_pend_ff)
    );

    uie_sticky u_xoff_pend (
        .clock   (clock),
        .rst     (rst),
        .set     (xoff_rcvd),
        .clr     (rd_src),
        .flag_ff (xoff_pend_ff)
    );

    uie_sticky u_modem_pend (
        .clock   (clock),
        .rst     (rst),
        .set     (modem_change),
        .clr     (modem_status_rd),
        .flag_ff (modem_pend_ff)
    );

    uie_sticky u_line_pend (
        .clock   (clock),
        .rst     (rst),
        .set     (any_err),
        .clr     (rd_lstat),
        .flag_ff (line_pend_ff)
    );

    // error kinds stay until the line status is read; a new error wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            err_ff <= 4'h0;
        end else if (rd_lstat) begin
            err_ff <= rx_err;
        end else begin
            err_ff <= err_ff | rx_err;
        end
    end

    // data ready sets with a push and clears once the fifo is empty
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dready_ff <= 1'b0;
        end else if (rx_push) begin
            dready_ff <= 1'b1;
        end else if (rx_fill == '0) begin
            dready_ff <= 1'b0;
        end
    end

    // receive level: trigger in fifo mode, one character otherwise
    assign rx_level = fifo_on ? (rx_fill >= rx_trigger) : dready_ff;

    always_comb begin
        lstat                          = 8'h00;
        lstat[uie_pkg::LB_DREADY]      = dready_ff;
        lstat[uie_pkg::LB_ERR_LO +: 4] = err_ff;
        lstat[uie_pkg::LB_THR_EMP]     = thr_empty;
        lstat[uie_pkg::LB_TX_IDLE]     = thr_empty & tsr_empty;
        lstat[uie_pkg::LB_FIFO_ERR]    = rx_fifo_err;
    end

    // source priority: line, receive, transmit, modem, xoff, handshake
    always_comb begin
        src_code = uie_pkg::SRC_NONE;
        if (interrupt_mask_ff[uie_pkg::MB_LINE] && line_pend_ff) begin
            src_code = uie_pkg::SRC_LINE;
        end else if (interrupt_mask_ff[uie_pkg::MB_RECEIVE_DMA_REQUEST_N] && rx_level) begin
            src_code = uie_pkg::SRC_RECEIVE_DMA_REQUEST_N;
        end else if (interrupt_mask_ff[uie_pkg::MB_TXEMP] && thr_empty) begin
            src_code = uie_pkg::SRC_TXEMP;
        end else if (interrupt_mask_ff[uie_pkg::MB_MODEM] && modem_pend_ff) begin
            src_code = uie_pkg::SRC_MODEM;
        end else if (interrupt_mask_ff[uie_pkg::MB_XOFF] && xoff_pend_ff) begin
            src_code = uie_pkg::SRC_XOFF;
        end else if ((interrupt_mask_ff[uie_pkg::MB_CTS] && cts_pend_ff)
                  || (interrupt_mask_ff[uie_pkg::MB_RTS] && rts_pend_ff)) begin
            src_code = uie_pkg::SRC_HSHAKE;
        end
    end

    // any enabled pending source drives the request; polled mode still lets mask bits 5-7 interrupt
    assign nxt_irq = (src_code != uie_pkg::SRC_NONE);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // 16 mode: own output; 68 mode: open-drain shared request, low active
    assign channel_irq    = irq_ff & ~bus_mode_68;
    assign shared_irq_out = 1'b0;
    assign shared_irq_oe  = irq_ff & bus_mode_68;

    // dma mode 0 ready levels; mode 1 is not served and stays inactive
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            transmit_dma_request_n_n_ff <= 1'b1;
            receive_dma_request_n_n_ff <= 1'b1;
        end else if (!fifo_on || !fifo_ctl_ff[uie_pkg::FB_DMA_SEL]) begin
            transmit_dma_request_n_n_ff <= ~thr_empty;
            receive_dma_request_n_n_ff <= (rx_fill == '0);
        end else begin
            transmit_dma_request_n_n_ff <= 1'b1;
            receive_dma_request_n_n_ff <= 1'b1;
        end
    end

    assign transmit_dma_request_n = transmit_dma_request_n_n_ff;
    assign receive_dma_request_n  = receive_dma_request_n_n_ff;

    assign mask_rd = enh_enable ? interrupt_mask_ff
                                : (interrupt_mask_ff & ~uie_pkg::MASK_ENH);

    // read data is captured on the read strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            if (divisor_latch_sel && reg_addr != uie_pkg::OFS_LSTAT) begin
                rdata_ff <= 8'h00;
            end else begin
                case (reg_addr)
                    uie_pkg::OFS_MASK:     rdata_ff <= mask_rd;
                    uie_pkg::OFS_FCTL_SRC: rdata_ff <= {fifo_on ? uie_pkg::SRC_FIFO_ON : 2'h0,
                                                        src_code};
                    uie_pkg::OFS_LSTAT:    rdata_ff <= lstat;
                    default:               rdata_ff <= 8'h00;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_ff;

    AST_MASK_RESET: assert property (@(posedge clock)
        $fell(rst) |-> interrupt_mask_ff == uie_pkg::MASK_RST)
        else $error("mask not zero after reset");
    AST_RESET_OUT: assert property (@(posedge clock) rst
        |-> !channel_irq && !shared_irq_oe && transmit_dma_request_n && receive_dma_request_n)
        else $error("outputs active during reset");
    AST_ENH_LOCK: assert property (@(posedge clock) disable iff (rst)
        wr_mask && !enh_enable |=> (interrupt_mask_ff & uie_pkg::MASK_ENH)
        == ($past(interrupt_mask_ff) & uie_pkg::MASK_ENH))
        else $error("upper mask bits changed while locked");
    AST_LOCK_READ: assert property (@(posedge clock) disable iff (rst)
        reg_rd && !divisor_latch_sel && reg_addr == uie_pkg::OFS_MASK && !enh_enable
        |=> (reg_rdata & uie_pkg::MASK_ENH) == 8'h00)
        else $error("locked mask bits readable");
    AST_CTS_IRQ: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_ff[uie_pkg::MB_CTS] && cts_rise && !rd_src |=> ##1 irq_ff)
        else $error("cts rise did not interrupt");
    AST_RTS_IRQ: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_ff[uie_pkg::MB_RTS] && rts_rise && !rd_src |=> ##1 irq_ff)
        else $error("rts rise did not interrupt");
    AST_XOFF_IRQ: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_ff[uie_pkg::MB_XOFF] && xoff_rcvd && !wr_mask |=> ##1 irq_ff)
        else $error("xoff did not interrupt");
    AST_MODEM_IRQ: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_ff[uie_pkg::MB_MODEM] && modem_change && !wr_mask |=> ##1 irq_ff)
        else $error("modem change did not interrupt");
    AST_LINE_IRQ: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_ff[uie_pkg::MB_LINE] && any_err && !wr_mask |=> ##1 irq_ff)
        else $error("line status error did not interrupt");
    AST_TX_EMPTY: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_ff[uie_pkg::MB_TXEMP] && thr_empty |=> irq_ff)
        else $error("holding empty did not interrupt");
    AST_MASKED_OFF: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_ff == 8'h00 |=> !irq_ff)
        else $error("interrupt with all sources masked");
    AST_RX_TRIG: assert property (@(posedge clock) disable iff (rst)
        fifo_on && interrupt_mask_ff[uie_pkg::MB_RECEIVE_DMA_REQUEST_N] && rx_fill >= rx_trigger |=> irq_ff)
        else $error("trigger level did not interrupt");
    AST_SRC_TRIG: assert property (@(posedge clock) disable iff (rst)
        rd_src && fifo_on && interrupt_mask_ff[uie_pkg::MB_RECEIVE_DMA_REQUEST_N] && rx_fill >= rx_trigger
        && !(interrupt_mask_ff[uie_pkg::MB_LINE] && line_pend_ff)
        |=> reg_rdata == {uie_pkg::SRC_FIFO_ON, uie_pkg::SRC_RECEIVE_DMA_REQUEST_N})
        else $error("receive trigger not shown in source register");
    AST_TX_IDLE: assert property (@(posedge clock) disable iff (rst)
        rd_lstat |=> reg_rdata[uie_pkg::LB_TX_IDLE] == ($past(thr_empty) && $past(tsr_empty)))
        else $error("idle shown while shifter busy");
    AST_FIFO_ERR: assert property (@(posedge clock) disable iff (rst)
        rd_lstat |=> reg_rdata[uie_pkg::LB_FIFO_ERR] == $past(rx_fifo_err))
        else $error("fifo data error not shown");
    AST_DMA_TX: assert property (@(posedge clock) disable iff (rst)
        !fifo_ctl_ff[uie_pkg::FB_DMA_SEL] && thr_empty |=> !transmit_dma_request_n)
        else $error("transmit request not low with space");
    AST_DMA_RX: assert property (@(posedge clock) disable iff (rst)
        (!fifo_on || !fifo_ctl_ff[uie_pkg::FB_DMA_SEL]) && rx_fill != '0
        |=> !receive_dma_request_n)
        else $error("receive request not low with data");
    AST_DREADY: assert property (@(posedge clock) disable iff (rst)
        rx_push |=> dready_ff)
        else $error("data ready not set after push");
    AST_DREADY_CLR: assert property (@(posedge clock) disable iff (rst)
        !rx_push && rx_fill == '0 |=> !dready_ff)
        else $error("data ready left set with fifo empty");
endmodule : uie_irq_ctrl

// [testbench/uie_host_model.sv]
// uie_host_model: host processor on the parallel register port
// assumes: single-byte strobes, inputs changed 1 ns after the rising edge
`timescale 1ns/100ps
module uie_host_model (
    input  wire logic       clock,
    output logic      [2:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 3'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clock);
        #1;
        reg_wr    = 1'b0;
        // released data no longer shows the last value
        reg_wdata = ~d;
    endtask : wr

    // polling reads status instead of taking interrupts
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clock);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : uie_host_model

// [testbench/uie_irq_ctrl_tb.sv]
// uie_irq_ctrl_tb: self-checking bench for the interrupt and status block
// assumes: host model drives the register port, bench drives channel status
`timescale 1ns/100ps
module uie_irq_ctrl_tb;
    logic       clock, rst, dls, enh, cts, rts, xoff, mchg, mrd, push, ferr;
    logic       thr_e, tsr_e, m68, sleep, irq, sh_out, sh_oe, tx_n, rx_n;
    logic [3:0] rx_err;
    logic [6:0] fill, trig;
    logic [2:0] addr;
    logic       wr, rd;
    logic [7:0] wdata, rdata, d;
    int         mismatches, comparisons;
    wire        shared_line = sh_oe ? sh_out : 1'b1;

    uie_host_model host (.clock(clock), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata));
    uie_irq_ctrl dut (.clock(clock), .rst(rst), .reg_addr(addr), .reg_wr(wr),
        .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .divisor_latch_sel(dls),
        .enh_enable(enh), .cts_level(cts), .rts_level(rts), .xoff_rcvd(xoff),
        .modem_change(mchg), .modem_status_rd(mrd), .rx_err(rx_err), .rx_push(push),
        .rx_fill(fill), .rx_trigger(trig), .rx_fifo_err(ferr), .thr_empty(thr_e),
        .tsr_empty(tsr_e), .bus_mode_68(m68), .sleep_enable(sleep), .channel_irq(irq),
        .shared_irq_out(sh_out), .shared_irq_oe(sh_oe), .transmit_dma_request_n(tx_n),
        .receive_dma_request_n(rx_n));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic tk(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask : tk

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic t_reset;
        host.rd(3'h1, d); chk(d, 8'h00);
        host.rd(3'h5, d); chk(d, 8'h60);
        chk({7'h00, sleep}, 8'h00);
    endtask : t_reset

    task automatic t_enh;
        host.wr(3'h1, 8'hff);
        host.rd(3'h1, d); chk(d, 8'h0f);
        enh = 1'b1;
        host.wr(3'h1, 8'h10);
        host.rd(3'h1, d); chk(d, 8'h10);
        chk({7'h00, sleep}, 8'h01);
        dls = 1'b1;
        host.rd(3'h1, d); chk(d, 8'h00);
        dls = 1'b0;
        host.wr(3'h1, 8'h02);
        tk(2); chk({7'h00, irq}, 8'h01);
        host.rd(3'h2, d); chk(d, 8'h02);
        thr_e = 1'b0;
        tk(2); chk({7'h00, irq}, 8'h00);
        thr_e = 1'b1;
    endtask : t_enh

    task automatic ev(input int i);
        case (i)
            0: cts = 1'b1;
            1: rts = 1'b1;
            default: xoff = 1'b1;
        endcase
        tk(1);
        {cts, rts, xoff} = 3'h0;
    endtask : ev

    task automatic t_events;
        logic [7:0] bitv[3] = '{8'h80, 8'h40, 8'h20};
        logic [7:0] code[3] = '{8'h20, 8'h20, 8'h10};
        for (int i = 0; i < 3; i++) begin
            host.wr(3'h1, 8'h00);
            ev(i);
            tk(3); chk({7'h00, irq}, 8'h00);
            host.rd(3'h2, d);
            host.wr(3'h1, bitv[i]);
            ev(i);
            tk(3); chk({7'h00, irq}, 8'h01);
            host.rd(3'h2, d); chk(d, code[i]);
            tk(3); chk({7'h00, irq}, 8'h00);
        end
    endtask : t_events

    task automatic t_rx;
        host.wr(3'h2, 8'h01);
        host.wr(3'h1, 8'h01);
        trig = 7'h04;
        fill = 7'h03;
        push = 1'b1;
        tk(1);
        push = 1'b0;
        tk(2); chk({7'h00, irq}, 8'h00);
        host.rd(3'h5, d); chk(d, 8'h61);
        fill = 7'h04;
        tk(2); chk({7'h00, irq}, 8'h01);
        host.rd(3'h2, d); chk(d, 8'hc4);
        fill = 7'h03;
        tk(2); chk({7'h00, irq}, 8'h00);
        host.rd(3'h2, d); chk(d, 8'hc1);
        fill = 7'h00;
        host.rd(3'h5, d); chk(d, 8'h60);
    endtask : t_rx

    task automatic t_line_modem;
        host.wr(3'h1, 8'h04);
        ferr   = 1'b1;
        rx_err = 4'h2;
        tk(1);
        rx_err = 4'h0;
        tk(2); chk({7'h00, irq}, 8'h01);
        host.rd(3'h2, d); chk(d, 8'hc6);
        host.rd(3'h5, d); chk(d, 8'he4);
        tk(3); chk({7'h00, irq}, 8'h00);
        ferr  = 1'b0;
        tsr_e = 1'b0;
        host.rd(3'h5, d); chk(d, 8'h20);
        tsr_e = 1'b1;
        host.wr(3'h1, 8'h08);
        mchg = 1'b1;
        tk(1);
        mchg = 1'b0;
        tk(2); chk({7'h00, irq}, 8'h01);
        host.rd(3'h2, d); chk(d, 8'hc0);
        mrd = 1'b1;
        tk(1);
        mrd = 1'b0;
        tk(2); chk({7'h00, irq}, 8'h00);
    endtask : t_line_modem

    task automatic t_dma_bus;
        thr_e = 1'b0;
        tk(2); chk({7'h00, tx_n}, 8'h01);
        thr_e = 1'b1;
        tk(2); chk({7'h00, tx_n}, 8'h00);
        fill = 7'h02;
        tk(2); chk({7'h00, rx_n}, 8'h00);
        fill = 7'h00;
        tk(2); chk({7'h00, rx_n}, 8'h01);
        host.wr(3'h1, 8'h02);
        m68 = 1'b1;
        tk(2); chk({6'h00, irq, shared_line}, 8'h00);
        m68 = 1'b0;
        tk(2); chk({6'h00, irq, shared_line}, 8'h03);
        // dma mode 1 is not served: both requests stay inactive
        host.wr(3'h2, 8'h09);
        tk(2); chk({6'h00, tx_n, rx_n}, 8'h03);
        // second reset in mid-run with a source enabled and pending
        rst = 1'b1;
        tk(2); chk({6'h00, irq, sleep}, 8'h00);
        rst = 1'b0;
        host.rd(3'h1, d); chk(d, 8'h00);
    endtask : t_dma_bus

    initial begin
        mismatches  = 0;
        comparisons = 0;
        {rst, dls, enh, cts, rts, xoff, mchg, mrd, push, ferr, m68} = 11'h400;
        {thr_e, tsr_e} = 2'h3;
        rx_err = 4'h0;
        fill   = 7'h00;
        trig   = 7'h01;
        tk(5);
        rst = 1'b0;
        t_reset();
        t_enh();
        t_events();
        t_rx();
        t_line_modem();
        t_dma_bus();
        report_and_stop();
    end

    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
endmodule : uie_irq_ctrl_tb
